// file: rtl/lsr_regs.sv
// register bank: display source selection, range limits, segment registers and custom offset
`timescale 1ns/1ps
`default_nettype none
module lsr_regs #(
  parameter bit          FOUR_HALF_DIGIT = 1'b1,
  parameter int unsigned DATA_W          = 16
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // register port from the serial interface
  input  wire logic [3:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic [15:0]           reg_wr_data,
  input  wire logic                  reg_rd,
  output logic [15:0]                reg_rd_data,
  input  wire logic                  cs_rise,
  // conversion side
  input  wire logic                  conv_valid,
  input  wire logic [15:0]           conv_calibrated,
  input  wire logic [15:0]           peak_value,
  // result and status
  output logic [15:0]                result_value,
  output logic                       result_valid,
  output logic                       over_limit_flag,
  output logic                       under_limit_flag,
  output logic                       peak_enable,
  // display
  output lsr_pkg::lsr_disp_t         display,
  output lsr_pkg::lsr_seg_t          segments
);

  // widths the logic is built for
  if (DATA_W != lsr_pkg::DATA_W) begin : g_bad_width
    $error("lsr_regs supports a 16-bit data path only");
  end

  // variant dependent reset values of the limits
  // over limit reset per variant
  localparam logic [15:0] OVER_RST  = FOUR_HALF_DIGIT ? lsr_pkg::OVER_RST_45 : lsr_pkg::OVER_RST_35;
  localparam logic [15:0] UNDER_RST = FOUR_HALF_DIGIT ? lsr_pkg::UNDER_RST_45 : lsr_pkg::UNDER_RST_35;

  // register state
  logic [15:0]        ctrl_q;
  logic [15:0]        over_limit_value_q;
  logic [15:0]        under_limit_value_q;
  logic [15:0]        segment_bits_low_q;
  logic [15:0]        segment_bits_mid_q;
  logic [7:0]         segment_bits_high_q;
  logic [15:0]        user_offset_value_q;
  logic [15:0]        lcd_data_q;
  logic [15:0]        result_q;
  logic               result_valid_q;
  logic [15:0]        rd_data_q;
  lsr_pkg::lsr_disp_t display_q;
  lsr_pkg::lsr_seg_t  segments_q;

  // decoded controls
  logic               host_select;
  logic               hold_select;
  logic               peak_select;
  logic               clear_all_bit;
  logic               direct_segment_select;
  logic               clear_all;
  logic               status_clr;
  logic               over_flag;
  logic               under_flag;
  logic               over_now;
  logic               under_now;
  lsr_pkg::lsr_src_t  src;
  lsr_pkg::lsr_seg_t  seg_mapped;
  lsr_pkg::lsr_disp_t display_d;
  logic [15:0]        rd_data_d;
  logic [15:0]        status_word;

  // write strobe for one register index
  function automatic logic wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] idx);
    wr_hit = wr && (addr == idx);
  endfunction

  // control fields
  assign host_select           = ctrl_q[lsr_pkg::CTRL_HOST_SEL_BIT];
  assign hold_select           = ctrl_q[lsr_pkg::CTRL_HOLD_BIT];
  assign peak_select           = ctrl_q[lsr_pkg::CTRL_PEAK_BIT];
  assign clear_all_bit         = ctrl_q[lsr_pkg::CTRL_CLEAR_ALL_BIT];
  assign direct_segment_select = ctrl_q[lsr_pkg::CTRL_DIRECT_SEG_BIT];

  // clear all on chip select rising edge
  assign clear_all  = cs_rise && clear_all_bit;
  assign status_clr = reg_rd && (reg_addr == lsr_pkg::REG_STATUS);

  // control register, reserved bit zero reads back as zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= lsr_pkg::CTRL_RST;
    end else if (clear_all) begin
      ctrl_q <= lsr_pkg::CTRL_RST;
    end else if (wr_hit(reg_wr, reg_addr, lsr_pkg::REG_CTRL)) begin
      ctrl_q <= reg_wr_data & lsr_pkg::RSVD_BIT0_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      over_limit_value_q <= OVER_RST;
    end else if (clear_all) begin
      over_limit_value_q <= OVER_RST;
    end else if (wr_hit(reg_wr, reg_addr, lsr_pkg::REG_OVER_LIM)) begin
      over_limit_value_q <= reg_wr_data;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      under_limit_value_q <= UNDER_RST;
    end else if (clear_all) begin
      under_limit_value_q <= UNDER_RST;
    end else if (wr_hit(reg_wr, reg_addr, lsr_pkg::REG_UNDER_LIM)) begin
      under_limit_value_q <= reg_wr_data;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      segment_bits_low_q  <= lsr_pkg::SEG_RST;
      segment_bits_mid_q  <= lsr_pkg::SEG_RST;
      segment_bits_high_q <= lsr_pkg::SEG_HIGH_RST;
    end else if (clear_all) begin
      segment_bits_low_q  <= lsr_pkg::SEG_RST;
      segment_bits_mid_q  <= lsr_pkg::SEG_RST;
      segment_bits_high_q <= lsr_pkg::SEG_HIGH_RST;
    end else begin
      if (wr_hit(reg_wr, reg_addr, lsr_pkg::REG_SEG_LOW)) begin
        segment_bits_low_q <= reg_wr_data & lsr_pkg::RSVD_BIT0_MASK;
      end
      if (wr_hit(reg_wr, reg_addr, lsr_pkg::REG_SEG_MID)) begin
        segment_bits_mid_q <= reg_wr_data & lsr_pkg::RSVD_BIT0_MASK;
      end
      if (wr_hit(reg_wr, reg_addr, lsr_pkg::REG_SEG_HIGH)) begin
        segment_bits_high_q <= reg_wr_data[7:0];
      end
    end
  end

  // custom offset register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      user_offset_value_q <= lsr_pkg::OFFSET_RST;
    end else if (clear_all) begin
      user_offset_value_q <= lsr_pkg::OFFSET_RST;
    end else if (wr_hit(reg_wr, reg_addr, lsr_pkg::REG_OFFSET)) begin
      user_offset_value_q <= reg_wr_data;
    end
  end

  // result is calibrated input minus offset, wrapping in 16 bits
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      result_q       <= lsr_pkg::RESULT_RST;
      result_valid_q <= 1'b0;
    end else if (clear_all) begin
      result_q       <= lsr_pkg::RESULT_RST;
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= conv_valid;
      if (conv_valid) begin
        result_q <= 16'(conv_calibrated - user_offset_value_q);
      end
    end
  end

  // display data register: host writes win, conversions load it unless held or host selected
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lcd_data_q <= lsr_pkg::LCD_DATA_RST;
    end else if (clear_all) begin
      lcd_data_q <= lsr_pkg::LCD_DATA_RST;
    end else if (wr_hit(reg_wr, reg_addr, lsr_pkg::REG_LCD_DATA)) begin
      lcd_data_q <= reg_wr_data;
    end else if (result_valid_q && !host_select && !hold_select) begin
      lcd_data_q <= peak_select ? peak_value : result_q;
    end
  end

  // limits checked on each new aligned result
  lsr_limit_cmp u_limit_cmp (
    .ref_clk           (ref_clk),
    .reset             (reset),
    .clear_all         (clear_all),
    .sample            (result_valid_q),
    .result            (result_q),
    .over_limit_value  (over_limit_value_q),
    .under_limit_value (under_limit_value_q),
    .status_clr        (status_clr),
    .over_flag_q       (over_flag),
    .under_flag_q      (under_flag),
    .over_now_q        (over_now),
    .under_now_q       (under_now)
  );

  // segment registers turned into driver segments
  lsr_seg_map #(
    .FOUR_HALF_DIGIT (FOUR_HALF_DIGIT)
  ) u_seg_map (
    .segment_bits_low  (segment_bits_low_q),
    .segment_bits_mid  (segment_bits_mid_q),
    .segment_bits_high (segment_bits_high_q),
    .seg_on            (seg_mapped)
  );

  always_comb begin
    if (direct_segment_select) begin
      // direct segments override every other select
      src = lsr_pkg::LSR_SRC_SEGMENTS;
    end else if (host_select) begin
      src = lsr_pkg::LSR_SRC_HOST;
    end else if (hold_select) begin
      src = lsr_pkg::LSR_SRC_HELD;
    end else if (peak_select) begin
      src = lsr_pkg::LSR_SRC_PEAK;
    end else begin
      src = lsr_pkg::LSR_SRC_LIVE;
    end
  end

  // display request for the chosen source
  always_comb begin
    display_d = '{show: lsr_pkg::LSR_SHOW_VALUE, value: 16'h0000};
    unique case (src)
      // data register hidden while segments are direct
      lsr_pkg::LSR_SRC_SEGMENTS: display_d.show = lsr_pkg::LSR_SHOW_SEGMENTS;
      lsr_pkg::LSR_SRC_HOST:     display_d.value = lcd_data_q;
      lsr_pkg::LSR_SRC_HELD:     display_d.value = lcd_data_q;
      lsr_pkg::LSR_SRC_PEAK:     display_d.value = peak_value;
      lsr_pkg::LSR_SRC_LIVE: begin
        display_d.value = result_q;
        if (over_now) begin
          display_d.show = lsr_pkg::LSR_SHOW_OVER;
        // minus one and dashes on underrange
        end else if (under_now) begin
          display_d.show = lsr_pkg::LSR_SHOW_UNDER;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      display_q  <= '{show: lsr_pkg::LSR_SHOW_VALUE, value: 16'h0000};
      segments_q <= '0;
    end else begin
      display_q  <= display_d;
      // segment drivers follow registers only in direct mode
      segments_q <= direct_segment_select ? seg_mapped : '0;
    end
  end

  // status word: over and under sticky flags
  always_comb begin
    status_word                          = 16'h0000;
    status_word[lsr_pkg::STAT_OVER_BIT]  = over_flag;
    status_word[lsr_pkg::STAT_UNDER_BIT] = under_flag;
  end

  // read multiplexer, unmapped indices read zero
  always_comb begin
    unique case (reg_addr)
      lsr_pkg::REG_CTRL:      rd_data_d = ctrl_q;
      lsr_pkg::REG_STATUS:    rd_data_d = status_word;
      lsr_pkg::REG_OVER_LIM:  rd_data_d = over_limit_value_q;
      lsr_pkg::REG_UNDER_LIM: rd_data_d = under_limit_value_q;
      lsr_pkg::REG_SEG_LOW:   rd_data_d = segment_bits_low_q;
      lsr_pkg::REG_SEG_MID:   rd_data_d = segment_bits_mid_q;
      lsr_pkg::REG_SEG_HIGH:  rd_data_d = {8'h00, segment_bits_high_q};
      lsr_pkg::REG_OFFSET:    rd_data_d = user_offset_value_q;
      lsr_pkg::REG_LCD_DATA:  rd_data_d = lcd_data_q;
      lsr_pkg::REG_RESULT:    rd_data_d = result_q;
      default:                rd_data_d = 16'h0000;
    endcase
  end

  // read data captured on the read strobe
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data_q <= 16'h0000;
    end else if (reg_rd) begin
      rd_data_q <= rd_data_d;
    end
  end

  // outputs
  assign reg_rd_data      = rd_data_q;
  assign result_value     = result_q;
  assign result_valid     = result_valid_q;
  assign over_limit_flag  = over_flag;
  assign under_limit_flag = under_flag;
  assign peak_enable      = peak_select;
  assign display          = display_q;
  assign segments         = segments_q;

endmodule
`default_nettype wire

// file: rtl/lsr_pkg.sv
// shared constants, register map and carrier types for the lcd source, range and segment register bank
package lsr_pkg;

  // data widths
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned SEG_HIGH_W = 8;
  localparam int unsigned ADDR_W     = 4;

  // register indices on the register port
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h1;
  localparam logic [3:0] REG_OVER_LIM  = 4'h2;
  localparam logic [3:0] REG_UNDER_LIM = 4'h3;
  localparam logic [3:0] REG_SEG_LOW   = 4'h4;
  localparam logic [3:0] REG_SEG_MID   = 4'h5;
  localparam logic [3:0] REG_SEG_HIGH  = 4'h6;
  localparam logic [3:0] REG_OFFSET    = 4'h7;
  localparam logic [3:0] REG_LCD_DATA  = 4'h8;
  localparam logic [3:0] REG_RESULT    = 4'h9;

  // values after reset
  localparam logic [15:0] CTRL_RST      = 16'h0000;
  localparam logic [15:0] OVER_RST_35   = 16'h7cf0;
  localparam logic [15:0] OVER_RST_45   = 16'h4e1f;
  localparam logic [15:0] UNDER_RST_35  = 16'h8300;
  localparam logic [15:0] UNDER_RST_45  = 16'hb1e0;
  localparam logic [15:0] SEG_RST       = 16'h0000;
  localparam logic [7:0]  SEG_HIGH_RST  = 8'h00;
  localparam logic [15:0] OFFSET_RST    = 16'h0000;
  localparam logic [15:0] LCD_DATA_RST  = 16'h0000;
  localparam logic [15:0] RESULT_RST    = 16'h0000;

  // control register field positions
  localparam int unsigned CTRL_HOST_SEL_BIT   = 15;
  localparam int unsigned CTRL_HOLD_BIT       = 7;
  localparam int unsigned CTRL_PEAK_BIT       = 6;
  localparam int unsigned CTRL_CLEAR_ALL_BIT  = 4;
  localparam int unsigned CTRL_DIRECT_SEG_BIT = 3;

  // status register field positions
  localparam int unsigned STAT_OVER_BIT  = 6;
  localparam int unsigned STAT_UNDER_BIT = 5;

  // reserved low bit of the control and 16-bit segment registers
  localparam logic [15:0] RSVD_BIT0_MASK = 16'hfffe;

  // display source, in falling priority
  typedef enum logic [2:0] {
    LSR_SRC_SEGMENTS,
    LSR_SRC_HOST,
    LSR_SRC_HELD,
    LSR_SRC_PEAK,
    LSR_SRC_LIVE
  } lsr_src_t;

  // what the lcd waveform generator is asked to render
  typedef enum logic [1:0] {
    LSR_SHOW_VALUE,
    LSR_SHOW_OVER,
    LSR_SHOW_UNDER,
    LSR_SHOW_SEGMENTS
  } lsr_show_t;

  // display request: mode and two's complement value
  typedef struct packed {
    lsr_show_t   show;
    logic [15:0] value;
  } lsr_disp_t;

  // one digit, active-high segment on
  typedef struct packed {
    logic dp;
    logic g;
    logic f;
    logic e;
    logic d;
    logic c;
    logic b;
    logic a;
  } lsr_digit_t;

  // every segment the driver can light, active-high on
  typedef struct packed {
    lsr_digit_t digit4;
    lsr_digit_t digit3;
    lsr_digit_t digit2;
    lsr_digit_t digit1;
    logic       minus_sign;
    logic       lead_one_pos5;
    logic       lead_one_pos4;
    logic       custom_ann;
    logic       battery_ann;
    logic       hold_ann;
    logic       peak_ann;
  } lsr_seg_t;

endpackage

// file: rtl/lsr_limit_cmp.sv
// signed over and under limit comparison with sticky status flags
`timescale 1ns/1ps
`default_nettype none
module lsr_limit_cmp (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clear_all,
  // result and limits
  input  wire logic        sample,
  input  wire logic [15:0] result,
  input  wire logic [15:0] over_limit_value,
  input  wire logic [15:0] under_limit_value,
  // status clear on read
  input  wire logic        status_clr,
  // flags
  output logic             over_flag_q,
  output logic             under_flag_q,
  output logic             over_now_q,
  output logic             under_now_q
);

  logic over_hit;
  logic under_hit;

  assign over_hit  = $signed(result) > $signed(over_limit_value);
  assign under_hit = $signed(result) < $signed(under_limit_value);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      over_now_q  <= 1'b0;
      under_now_q <= 1'b0;
    end else if (clear_all) begin
      over_now_q  <= 1'b0;
      under_now_q <= 1'b0;
    end else if (sample) begin
      over_now_q  <= over_hit;
      under_now_q <= under_hit;
    end
  end

  // over flag latches, set beats clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      over_flag_q <= 1'b0;
    end else if (clear_all) begin
      over_flag_q <= 1'b0;
    end else if (sample && over_hit) begin
      over_flag_q <= 1'b1;
    end else if (status_clr) begin
      over_flag_q <= 1'b0;
    end
  end

  // under flag sets, set beats clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      under_flag_q <= 1'b0;
    end else if (clear_all) begin
      under_flag_q <= 1'b0;
    end else if (sample && under_hit) begin
      under_flag_q <= 1'b1;
    end else if (status_clr) begin
      under_flag_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: rtl/lsr_seg_map.sv
// maps the three active-low segment registers onto active-high driver segments
`timescale 1ns/1ps
`default_nettype none
module lsr_seg_map #(
  parameter bit FOUR_HALF_DIGIT = 1'b1
) (
  // segment registers
  input  wire logic [15:0] segment_bits_low,
  input  wire logic [15:0] segment_bits_mid,
  input  wire logic [7:0]  segment_bits_high,
  // driver segments
  output lsr_pkg::lsr_seg_t seg_on
);

  logic [15:0] lo_on;
  logic [15:0] mid_on;
  logic [7:0]  hi_on;

  // a zero bit lights its segment
  assign lo_on  = ~segment_bits_low;
  assign mid_on = ~segment_bits_mid;
  assign hi_on  = ~segment_bits_high;

  assign seg_on.digit2.a    = lo_on[15];
  assign seg_on.digit2.g    = lo_on[14];
  assign seg_on.digit2.d    = lo_on[13];
  assign seg_on.digit2.f    = lo_on[12];
  assign seg_on.digit2.e    = lo_on[11];
  assign seg_on.digit2.dp   = lo_on[10];
  assign seg_on.custom_ann  = lo_on[9];
  assign seg_on.digit1      = '{dp: lo_on[1], g: lo_on[5], f: lo_on[3], e: lo_on[2],
                                d: lo_on[4], c: lo_on[7], b: lo_on[8], a: lo_on[6]};

  assign seg_on.minus_sign  = mid_on[12];
  assign seg_on.digit3      = '{dp: mid_on[4], g: mid_on[8], f: mid_on[6], e: mid_on[5],
                                d: mid_on[7], c: mid_on[10], b: mid_on[11], a: mid_on[9]};
  assign seg_on.battery_ann = mid_on[3];
  assign seg_on.digit2.b    = mid_on[2];
  assign seg_on.digit2.c    = mid_on[1];

  assign seg_on.peak_ann    = hi_on[7];
  assign seg_on.hold_ann    = hi_on[6];

  // leading one goes to position five or four
  assign seg_on.lead_one_pos5 = FOUR_HALF_DIGIT ? hi_on[5] : 1'b0;
  assign seg_on.lead_one_pos4 = FOUR_HALF_DIGIT ? 1'b0 : hi_on[5];

  // digit four only exists on the wider panel
  assign seg_on.digit4 = FOUR_HALF_DIGIT ?
    lsr_pkg::lsr_digit_t'{dp: mid_on[13], g: hi_on[1], f: mid_on[15], e: mid_on[14],
                          d: hi_on[0], c: hi_on[3], b: hi_on[4], a: hi_on[2]} : lsr_pkg::lsr_digit_t'(8'h00);

endmodule
`default_nettype wire

// file: tb/lsr_host_model.sv
// host side model driving the register port of the bank
`timescale 1ns/1ps
`default_nettype none
module lsr_host_model (
  // clock
  input  wire logic        ref_clk,
  // register port
  output logic [3:0]       reg_addr,
  output logic             reg_wr,
  output logic [15:0]      reg_wr_data,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rd_data,
  output logic             cs_rise
);
  // idle port from time zero
  initial begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_wr_data = 16'h0000;
    reg_rd = 1'b0;
    cs_rise = 1'b0;
  end
  // one write; data lines scrambled once released
  task automatic wr(input logic [3:0] a, input logic [15:0] x);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wr_data <= x;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wr_data <= ~x;
  endtask
  // one read; data taken after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [15:0] x);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    x = reg_rd_data;
  endtask
  // chip select rising edge pulse
  task automatic csr();
    @(posedge ref_clk);
    cs_rise <= 1'b1;
    @(posedge ref_clk);
    cs_rise <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/lsr_regs_assertions.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module lsr_regs_assertions (
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               reset,
  // register port
  input wire logic [3:0]         reg_addr,
  input wire logic               reg_rd,
  input wire logic [15:0]        reg_rd_data,
  input wire logic               cs_rise,
  // conversion, flags and display
  input wire logic               conv_valid,
  input wire logic               result_valid,
  input wire logic               over_limit_flag,
  input wire logic               under_limit_flag,
  input wire lsr_pkg::lsr_disp_t display,
  input wire lsr_pkg::lsr_seg_t  segments
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // direct segment mode shown
  wire logic seg_show = display.show == lsr_pkg::LSR_SHOW_SEGMENTS;
  rv_after_conv_a: assert property (conv_valid |=> result_valid) else $error("result valid missing");
  rv_cause_a: assert property (result_valid |-> $past(conv_valid)) else $error("stray result valid");
  seg_value_a: assert property (seg_show |-> display.value == 16'h0000) else $error("value in segment mode");
  seg_idle_a: assert property (segments != '0 |-> seg_show || $past(seg_show)) else $error("segments lit");
  over_rise_a: assert property ($rose(over_limit_flag) |-> $past(conv_valid, 2)) else $error("over flag early");
  under_rise_a: assert property ($rose(under_limit_flag) |-> $past(conv_valid, 2)) else $error("under flag early");
  flag_hold_a: assert property ($fell(over_limit_flag) || $fell(under_limit_flag) |->
    ($past(reg_rd) && $past(reg_addr) == lsr_pkg::REG_STATUS) || $past(cs_rise)) else $error("flag dropped");
  rsvd_bit_a: assert property (reg_rd && reg_addr == lsr_pkg::REG_SEG_LOW |=> reg_rd_data[0] == 1'b0)
    else $error("bit0 set");
  high_pad_a: assert property (reg_rd && reg_addr == lsr_pkg::REG_SEG_HIGH |=> reg_rd_data[15:8] == 8'h00)
    else $error("high byte set");
  cover property (display.show == lsr_pkg::LSR_SHOW_OVER);
  cover property (display.show == lsr_pkg::LSR_SHOW_UNDER);
  cover property (seg_show);
endmodule
bind lsr_regs lsr_regs_assertions chk_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .cs_rise(cs_rise), .conv_valid(conv_valid),
  .result_valid(result_valid), .over_limit_flag(over_limit_flag), .under_limit_flag(under_limit_flag),
  .display(display), .segments(segments));
`default_nettype wire

// file: tb/tb_lsr_regs.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module tb_lsr_regs;
  // design ports and bench state
  logic               ref_clk, reset, reg_wr, reg_rd, cs_rise, conv_valid;
  logic               result_valid, over_limit_flag, under_limit_flag, peak_enable;
  logic [3:0]         reg_addr;
  logic [15:0]        reg_wr_data, reg_rd_data, conv_calibrated, peak_value, result_value;
  lsr_pkg::lsr_disp_t display;
  lsr_pkg::lsr_seg_t  segments, seg_exp;
  logic [15:0]        d, v, o, p;
  int                 bad_count, tests_run;
  lsr_regs dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wr_data(reg_wr_data), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .cs_rise(cs_rise),
    .conv_valid(conv_valid), .conv_calibrated(conv_calibrated), .peak_value(peak_value),
    .result_value(result_value), .result_valid(result_valid), .over_limit_flag(over_limit_flag),
    .under_limit_flag(under_limit_flag), .peak_enable(peak_enable), .display(display), .segments(segments));
  lsr_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wr_data(reg_wr_data),
    .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .cs_rise(cs_rise));
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // compare and count
  task automatic chk(input string name, input logic [38:0] seen, input logic [38:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // verdict
  task automatic end_sim();
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // expected reset value and readable bits per index
  function automatic logic [15:0] rst_val(input int i);
    return (i == 2) ? lsr_pkg::OVER_RST_45 : (i == 3) ? lsr_pkg::UNDER_RST_45 : 16'h0000;
  endfunction
  function automatic logic [15:0] rd_mask(input int i);
    return (i == 4 || i == 5) ? lsr_pkg::RSVD_BIT0_MASK : (i == 6) ? 16'h00ff : 16'hffff;
  endfunction
  // one conversion, then result and display once settled
  task automatic cv(input logic [15:0] x, input logic [1:0] sh, input logic [15:0] ev);
    @(posedge ref_clk);
    conv_valid <= 1'b1;
    conv_calibrated <= x;
    @(posedge ref_clk);
    conv_valid <= 1'b0;
    conv_calibrated <= ~x;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("result", result_value, 16'(x - o));
    chk("show", display.show, sh);
    if (sh == 2'd0) chk("value", display.value, ev);
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    end_sim();
  end
  // main sequence
  initial begin
    reset = 1'b1;
    conv_valid = 1'b0;
    conv_calibrated = 16'h0000;
    peak_value = 16'h0000;
    bad_count = 0;
    tests_run = 0;
    o = 16'h0000;
    void'($urandom(11906));
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 2; i < 9; i++) begin
      host_u.rd(i[3:0], d);
      chk("reset value", d, rst_val(i));
      v = 16'($urandom);
      host_u.wr(i[3:0], v);
      host_u.rd(i[3:0], d);
      chk("read back", d, v & rd_mask(i));
    end
    host_u.wr(4'hc, v);
    host_u.rd(4'hc, d);
    chk("unmapped", d, 16'h0000);
    o = 16'($urandom);
    host_u.wr(lsr_pkg::REG_OFFSET, o);
    host_u.wr(lsr_pkg::REG_CTRL, 16'h0000);
    host_u.wr(lsr_pkg::REG_OVER_LIM, 16'h0100);
    host_u.wr(lsr_pkg::REG_UNDER_LIM, 16'hff00);
    host_u.rd(lsr_pkg::REG_STATUS, d);
    cv(16'h0101 + o, 2'd1, 16'h0000);
    cv(16'h0100 + o, 2'd0, 16'h0100);
    cv(16'hfeff + o, 2'd2, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      v = 16'($urandom_range(0, 512)) - 16'h0100;
      cv(v + o, 2'd0, v);
    end
    host_u.rd(lsr_pkg::REG_STATUS, d);
    chk("status", d, 16'h0060);
    host_u.rd(lsr_pkg::REG_STATUS, d);
    chk("status cleared", d, 16'h0000);
    p = 16'($urandom);
    peak_value <= p;
    host_u.wr(lsr_pkg::REG_CTRL, 16'h0040);
    cv(o, 2'd0, p);
    chk("peak enable", peak_enable, 1'b1);
    peak_value <= ~p;
    host_u.wr(lsr_pkg::REG_CTRL, 16'h00c0);
    cv(o + 16'h0005, 2'd0, p);
    v = 16'($urandom);
    host_u.wr(lsr_pkg::REG_LCD_DATA, v);
    host_u.wr(lsr_pkg::REG_CTRL, 16'h8040);
    cv(o, 2'd0, v);
    host_u.wr(lsr_pkg::REG_SEG_LOW, 16'h0200);
    host_u.wr(lsr_pkg::REG_SEG_MID, 16'hfffe);
    host_u.wr(lsr_pkg::REG_SEG_HIGH, 16'h0080);
    host_u.wr(lsr_pkg::REG_CTRL, 16'h80c8);
    cv(o, 2'd3, 16'h0000);
    seg_exp = '0;
    seg_exp.digit1 = 8'hff;
    seg_exp.digit2 = 8'hf9;
    seg_exp.digit4 = 8'h4f;
    seg_exp.lead_one_pos5 = 1'b1;
    seg_exp.hold_ann = 1'b1;
    chk("segments", segments, seg_exp);
    host_u.wr(lsr_pkg::REG_CTRL, 16'h0018);
    host_u.csr();
    host_u.rd(lsr_pkg::REG_OVER_LIM, d);
    chk("clear all", d, lsr_pkg::OVER_RST_45);
    host_u.rd(lsr_pkg::REG_SEG_MID, d);
    chk("clear all", d, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
